// ---- ufc_line_control.sv ----
// Purpose: FIFO, line format and modem control registers of a serial port
// Assumes: host bus in mclk domain; FIFO levels and data paths are outside
// Notes:   level counts come from the FIFOs; flush pulses go back to them
// Summary of operation
// - FIFO enable bit gates all other bits
// - Receive FIFO reset clears pointers, self-clears
// - Transmit FIFO reset clears pointers, self-clears
// - Wake-up enable gated, needs enhanced bit
// - Transmit interrupt below trigger or on empty
// - Transmit trigger table 1, 4, 8, 14
// - Receive interrupt at receive trigger level
// - Each direction reads its own trigger select field
// - Low bits set five to eight data bits
// - One, one-and-half or two stop bits
// - Parity enable adds and checks parity
// - Even bit picks odd or even parity
// - Forced parity is one or zero
// - Break holds serial output low
// - Divisor bit redirects shared addresses
// - Terminal-ready bit drives inverted pin
// - Request-to-send bit drives inverted pin
// - Bit two feeds looped ring indicator
// - Bit three gates interrupt pin, loop output
// - Status top bits show FIFO enable
`timescale 1ns/1ps
module ufc_line_control (
  mclk,
  reset,
  bus,
  enhanced_en,
  strobe_mode,
  irq_raw,
  tx_level,
  rx_level,
  tx_serial_in,
  rdata,
  fifo_enabled,
  rx_flush,
  tx_flush,
  tx_irq,
  rx_irq,
  wake_irq_en,
  fmt,
  sel_divisor,
  sel_data,
  tx_serial_out,
  terminal_ready_n,
  request_to_send_n,
  user_output_one_n,
  user_output_two_n,
  loop_enable,
  int_out,
  int_oe_n
);
  import ufc_pkg::*;
  input  wire logic               mclk;
  input  wire logic               reset;
  input  ufc_pkg::ufc_bus_type    bus;
  input  wire logic               enhanced_en;
  input  wire logic               strobe_mode;
  input  wire logic               irq_raw;
  input  wire logic [4:0]         tx_level;
  input  wire logic [4:0]         rx_level;
  input  wire logic               tx_serial_in;
  output logic [7:0]              rdata;
  output logic                    fifo_enabled;
  output logic                    rx_flush;
  output logic                    tx_flush;
  output logic                    tx_irq;
  output logic                    rx_irq;
  output logic                    wake_irq_en;
  output ufc_pkg::ufc_format_type fmt;
  output logic                    sel_divisor;
  output logic                    sel_data;
  output logic                    tx_serial_out;
  output logic                    terminal_ready_n;
  output logic                    request_to_send_n;
  output logic                    user_output_one_n;
  output logic                    user_output_two_n;
  output logic                    loop_enable;
  output logic                    int_out;
  output logic                    int_oe_n;

  logic [7:0] fifo_ctl_r;
  logic [7:0] line_r;
  logic [7:0] modem_r;
  logic       rx_flush_r;
  logic       tx_flush_r;
  logic       tx_armed_r;
  logic       tx_irq_r;
  logic       rx_irq_r;
  logic [7:0] rdata_r;
  logic       tx_out_r;
  logic [4:0] tx_trig;
  logic [4:0] rx_trig;
  logic [4:0] trig_lvl [2];
  logic       strobe_meta_r;
  logic       strobe_sync_r;

  // One compare serves write strobes and read select alike
  function automatic logic addr_is(input logic [2:0] a, input logic [2:0] target);
    return (a == target);
  endfunction

  // Bus decode
  wire logic wr_fifo  = bus.wr & addr_is(bus.addr, ADDR_FIFO_ISR);
  wire logic wr_line  = bus.wr & addr_is(bus.addr, ADDR_LINE);
  wire logic wr_modem = bus.wr & addr_is(bus.addr, ADDR_MODEM);
  wire logic fifo_go  = wr_fifo & bus.wdata[FC_EN];
  wire logic fifo_on  = fifo_ctl_r[FC_EN];

  // Transmit trigger and wake bits only move with the enhanced gate open
  wire logic [7:0] fifo_ctl_nxt = {bus.wdata[7:6],
    enhanced_en ? bus.wdata[5:3] : fifo_ctl_r[5:3],
    3'h1};

  // One decoder per direction: index 0 transmit, index 1 receive
  for (genvar g = 0; g < 2; g++) begin : g_trig
    localparam int SEL_LO = (g == 0) ? FC_TXT_LO : FC_RXT_LO;
    ufc_trigger_decode u_trig (
      .sel   (fifo_ctl_r[SEL_LO +: 2]),
      .level (trig_lvl[g])
    );
  end

  assign tx_trig = trig_lvl[0];
  assign rx_trig = trig_lvl[1];

  ufc_format_decode u_fmt (
    .line_reg (line_r),
    .fmt      (fmt)
  );

  // Registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fifo_ctl_r <= REG_RESET;
    end else if (wr_fifo) begin
      // Clearing bit 0 disables FIFOs; other bits ignored then
      fifo_ctl_r <= fifo_go ? fifo_ctl_nxt : REG_RESET;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      line_r  <= REG_RESET;
    end else if (wr_line) begin
      line_r  <= bus.wdata;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      modem_r <= REG_RESET;
    end else if (wr_modem) begin
      modem_r <= bus.wdata;
    end
  end

  // Flush strobes last one cycle; bits never store
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_flush_r <= 1'b0;
      tx_flush_r <= 1'b0;
    end else begin
      rx_flush_r <= fifo_go & bus.wdata[FC_RX_RST];
      tx_flush_r <= fifo_go & bus.wdata[FC_TX_RST];
    end
  end

  // Transmit and receive interrupt conditions
  wire logic tx_empty    = (tx_level == 5'h00);
  wire logic tx_above    = (tx_level > tx_trig);
  wire logic tx_below    = (tx_level < tx_trig);
  // FIFOs off: holding register is one deep, so empty is the trigger
  wire logic tx_cond     = fifo_on ? (tx_armed_r ? tx_below : tx_empty)
                                   : tx_empty;
  wire logic rx_cond     = fifo_on ? (rx_level >= rx_trig)
                                   : (rx_level != 5'h00);

  // Armed once a reload filled past the trigger; held until empty
  // so the request keeps standing while the FIFO drains
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_armed_r <= 1'b0;
    end else if (tx_flush_r | tx_empty) begin
      tx_armed_r <= 1'b0;
    end else if (tx_above) begin
      tx_armed_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_irq_r <= 1'b0;
      rx_irq_r <= 1'b0;
    end else begin
      tx_irq_r <= tx_cond;
      rx_irq_r <= rx_cond;
    end
  end

  // Read path
  wire logic [7:0] isr_view = {fifo_on ? ISR_FIFO_ON : 2'h0, 6'h01};
  wire logic [7:0] rd_mux =
    addr_is(bus.addr, ADDR_FIFO_ISR) ? isr_view :
    addr_is(bus.addr, ADDR_LINE)     ? line_r   :
    addr_is(bus.addr, ADDR_MODEM)    ? modem_r  : REG_RESET;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_r <= REG_RESET;
    end else if (bus.rd) begin
      rdata_r <= rd_mux;
    end
  end

  // Mode pin comes from the board; two stages keep metastability out
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      strobe_meta_r <= 1'b0;
      strobe_sync_r <= 1'b0;
    end else begin
      strobe_meta_r <= strobe_mode;
      strobe_sync_r <= strobe_meta_r;
    end
  end

  // Break overrides serial data
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_out_r <= 1'b1;
    end else begin
      tx_out_r <= tx_serial_in & ~line_r[LF_BREAK];
    end
  end

  assign rdata             = rdata_r;
  assign fifo_enabled      = fifo_on;
  assign rx_flush          = rx_flush_r;
  assign tx_flush          = tx_flush_r;
  assign tx_irq            = tx_irq_r;
  assign rx_irq            = rx_irq_r;
  assign wake_irq_en       = fifo_ctl_r[FC_WAKE];
  assign sel_divisor       = line_r[LF_DIV];
  assign sel_data          = ~line_r[LF_DIV];
  assign tx_serial_out     = tx_out_r;
  assign loop_enable       = modem_r[ML_LOOP];
  // Loopback keeps terminal-ready and request-to-send pins idle
  assign terminal_ready_n  = ~modem_r[ML_TERM] | modem_r[ML_LOOP];
  assign request_to_send_n = ~modem_r[ML_RTS] | modem_r[ML_LOOP];
  assign user_output_one_n = ~modem_r[ML_OUT1];
  assign user_output_two_n = ~modem_r[ML_OUT2];
  assign int_out           = irq_raw;
  // Strobe mode: pin floats until bit 3 set; other mode always driven
  // Mode changes reach the enable two cycles late through the synchroniser
  assign int_oe_n          = strobe_sync_r & ~modem_r[ML_OUT2];
endmodule // ufc_line_control

// ---- ufc_pkg.sv ----
// Purpose: shared constants and types for the serial line control block
// Assumes: 8-bit register bus with 3-bit address, one device clock
// Notes:   addresses are local choices where none is printed
package ufc_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 3;
  localparam int          LVL_W         = 5;
  // Register addresses
  localparam logic [2:0]  ADDR_DATA     = 3'h0;
  localparam logic [2:0]  ADDR_DIV_HIGH = 3'h1;
  localparam logic [2:0]  ADDR_FIFO_ISR = 3'h2;
  localparam logic [2:0]  ADDR_LINE     = 3'h3;
  localparam logic [2:0]  ADDR_MODEM    = 3'h4;
  // fifo_control fields
  localparam int          FC_EN         = 0;
  localparam int          FC_RX_RST     = 1;
  localparam int          FC_TX_RST     = 2;
  localparam int          FC_WAKE       = 3;
  localparam int          FC_TXT_LO     = 4;
  localparam int          FC_RXT_LO     = 6;
  // line_format_control fields
  localparam int          LF_STOP       = 2;
  localparam int          LF_PAR_EN     = 3;
  localparam int          LF_EVEN       = 4;
  localparam int          LF_FORCE      = 5;
  localparam int          LF_BREAK      = 6;
  localparam int          LF_DIV        = 7;
  // modem_line_control fields
  localparam int          ML_TERM       = 0;
  localparam int          ML_RTS        = 1;
  localparam int          ML_OUT1       = 2;
  localparam int          ML_OUT2       = 3;
  localparam int          ML_LOOP       = 4;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [1:0]  ISR_FIFO_ON   = 2'h3;
  // Trigger table entries
  localparam logic [4:0]  TRIG_1        = 5'h01;
  localparam logic [4:0]  TRIG_4        = 5'h04;
  localparam logic [4:0]  TRIG_8        = 5'h08;
  localparam logic [4:0]  TRIG_14       = 5'h0e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ufc_bus_type;

  typedef struct packed {
    logic [3:0] data_bits;
    logic       stop_half;
    logic       stop_two;
    logic       par_en;
    logic       par_forced;
    logic       par_value;
    logic       par_even;
    logic       brk;
  } ufc_format_type;

  typedef enum logic [1:0] {
    UFC_IDLE,
    UFC_FLUSH
  } ufc_flush_type;
endpackage

// ---- ufc_trigger_decode.sv ----
// Purpose: map a 2-bit trigger selection to a character level
// Assumes: selection code 00 -> 1, 01 -> 4, 10 -> 8, 11 -> 14
// Notes:   shared by transmit and receive sides
`timescale 1ns/1ps
module ufc_trigger_decode (
  sel,
  level
);
  import ufc_pkg::*;
  input  wire logic [1:0] sel;
  output logic [4:0]      level;

  assign level = (sel == 2'h0) ? TRIG_1 :
                 (sel == 2'h1) ? TRIG_4 :
                 (sel == 2'h2) ? TRIG_8 : TRIG_14;
endmodule // ufc_trigger_decode

// ---- ufc_format_decode.sv ----
// Purpose: decode line format register into serial frame settings
// Assumes: line register value is stable in the mclk domain
// Notes:   pure combinational
`timescale 1ns/1ps
module ufc_format_decode (
  line_reg,
  fmt
);
  import ufc_pkg::*;
  input  wire logic [7:0]     line_reg;
  output ufc_pkg::ufc_format_type fmt;

  wire logic [1:0] len_sel = line_reg[1:0];
  wire logic       is_five = (len_sel == 2'h0);

  assign fmt.data_bits  = 4'h5 + {2'h0, len_sel};
  assign fmt.stop_half  = line_reg[LF_STOP] & is_five;
  assign fmt.stop_two   = line_reg[LF_STOP] & ~is_five;
  assign fmt.par_en     = line_reg[LF_PAR_EN];
  assign fmt.par_forced = line_reg[LF_PAR_EN] & line_reg[LF_FORCE];
  assign fmt.par_value  = ~line_reg[LF_EVEN];
  assign fmt.par_even   = line_reg[LF_EVEN];
  assign fmt.brk        = line_reg[LF_BREAK];
endmodule // ufc_format_decode

// ---- ufc_host_model.sv ----
// Purpose: host processor model on the register bus
// Assumes: one strobe a transfer, taken at the next mclk edge
// Notes:   idle bus shows inverted address and data
`timescale 1ns/1ps
module ufc_host_model (
  input  wire logic            mclk,
  input  wire logic [7:0]      rdata,
  output ufc_pkg::ufc_bus_type bus
);
  import ufc_pkg::*;
  initial bus = '0;
  task automatic write(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic read(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
    #1 d = rdata;
  endtask
endmodule // ufc_host_model

// ---- ufc_line_control_props.sv ----
// Purpose: port checks of the serial line control block
// Assumes: one clock domain, async active-high reset
// Notes:   register contents are inferred from bus writes
`timescale 1ns/1ps
module ufc_line_control_props (
  input wire logic            mclk,
  input wire logic            reset,
  input ufc_pkg::ufc_bus_type bus,
  input wire logic            strobe_mode,
  input wire logic [4:0]      rx_level,
  input wire logic [7:0]      rdata,
  input wire logic            fifo_enabled,
  input wire logic            rx_flush,
  input wire logic            tx_flush,
  input wire logic            rx_irq,
  input ufc_pkg::ufc_format_type fmt,
  input wire logic            sel_divisor,
  input wire logic            sel_data,
  input wire logic            tx_serial_out,
  input wire logic            terminal_ready_n,
  input wire logic            request_to_send_n,
  input wire logic            user_output_two_n,
  input wire logic            int_oe_n
);
  import ufc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire fc_wr = bus.wr && bus.addr == ADDR_FIFO_ISR;
  wire ml_wr = bus.wr && bus.addr == ADDR_MODEM;
  fifo_enable_a: assert property (fc_wr |=> fifo_enabled == $past(bus.wdata[FC_EN]))
    else $error("fifo enable does not follow write");
  flush_pulse_a: assert property (fc_wr && bus.wdata[FC_EN] && bus.wdata[FC_RX_RST]
    |=> rx_flush ##1 (!rx_flush || $past(fc_wr && bus.wdata[FC_EN] && bus.wdata[FC_RX_RST])))
    else $error("receive flush not a single pulse");
  flush_gated_a: assert property (fc_wr && !bus.wdata[FC_EN] |=> !rx_flush && !tx_flush)
    else $error("flush without fifo enable");
  break_low_a: assert property (fmt.brk |=> !tx_serial_out)
    else $error("serial output high during break");
  divisor_sel_a: assert property (bus.wr && bus.addr == ADDR_LINE
    |=> sel_divisor == $past(bus.wdata[LF_DIV]) && sel_data != sel_divisor)
    else $error("divisor select wrong");
  modem_pins_a: assert property (ml_wr && !bus.wdata[ML_LOOP]
    |=> terminal_ready_n == !$past(bus.wdata[ML_TERM])
        && request_to_send_n == !$past(bus.wdata[ML_RTS])) else $error("modem pin wrong");
  int_float_a: assert property (int_oe_n == ($past(strobe_mode, 2) && user_output_two_n))
    else $error("interrupt pin enable wrong");
  status_top_a: assert property (bus.rd && bus.addr == ADDR_FIFO_ISR
    |=> rdata[7:6] == {2{fifo_enabled}}) else $error("status top bits wrong");
  rx_trigger_a: assert property (fifo_enabled && rx_level >= 5'h0e |=> rx_irq)
    else $error("receive interrupt missing");
  word_len_a: assert property (fmt.data_bits >= 4'h5 && fmt.data_bits <= 4'h8)
    else $error("word length out of range");
  stop_half_a: assert property (fmt.stop_half |-> fmt.data_bits == 4'h5 && !fmt.stop_two)
    else $error("half stop bit on long word");
endmodule // ufc_line_control_props
bind ufc_line_control ufc_line_control_props ufc_line_control_props_i (.mclk, .reset, .bus,
  .strobe_mode, .rx_level, .rdata, .fifo_enabled, .rx_flush, .tx_flush, .rx_irq, .fmt,
  .sel_divisor, .sel_data, .tx_serial_out, .terminal_ready_n, .request_to_send_n,
  .user_output_two_n, .int_oe_n);

// ---- test_ufc_line_control.sv ----
// Purpose: self-checking bench of the serial line control block
// Assumes: host model drives the bus, levels driven here
// Notes:   random line and modem values from a fixed seed
`timescale 1ns/1ps
module test_ufc_line_control;
  import ufc_pkg::*;
  logic mclk, reset, enhanced_en, strobe_mode, irq_raw, tx_serial_in;
  logic [4:0] tx_level, rx_level;
  logic [7:0] rdata, d, v;
  ufc_bus_type bus;
  ufc_format_type fmt;
  logic fifo_enabled, rx_flush, tx_flush, tx_irq, rx_irq, wake_irq_en, sel_divisor, sel_data;
  logic tx_serial_out, terminal_ready_n, request_to_send_n, user_output_one_n;
  logic user_output_two_n, loop_enable, int_out, int_oe_n;
  int bad_count, n_compared, seed;
  ufc_line_control ufc_line_control_i (.mclk, .reset, .bus, .enhanced_en, .strobe_mode,
    .irq_raw, .tx_level, .rx_level, .tx_serial_in, .rdata, .fifo_enabled, .rx_flush,
    .tx_flush, .tx_irq, .rx_irq, .wake_irq_en, .fmt, .sel_divisor, .sel_data,
    .tx_serial_out, .terminal_ready_n, .request_to_send_n, .user_output_one_n,
    .user_output_two_n, .loop_enable, .int_out, .int_oe_n);
  ufc_host_model ufc_host_model_i (.mclk, .rdata, .bus);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [4:0] trig(input logic [1:0] c);
    return c == 2'h0 ? 5'h01 : c == 2'h1 ? 5'h04 : c == 2'h2 ? 5'h08 : 5'h0e;
  endfunction
  function automatic logic [7:0] exp_fmt(input logic [7:0] x);
    return {4'h5 + {2'h0, x[1:0]}, x[3], x[6], x[2] && x[1:0] != 2'h0, x[2] && x[1:0] == 2'h0};
  endfunction
  // Levels change at an edge, irq is sampled once its pipeline has settled
  task automatic step(input logic [4:0] rx, input logic [4:0] tx);
    @(posedge mclk);
    rx_level <= rx;
    tx_level <= tx;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  initial begin
    repeat (4000) @(posedge mclk);
    bad_count++;
    complete_run;
  end
  initial begin
    seed = 32'h0960;
    {reset, enhanced_en, strobe_mode, irq_raw, tx_serial_in} = 5'h13;
    {tx_level, rx_level} = 10'h000;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    foreach (d[i]) begin
      ufc_host_model_i.read(3'(i), v);
      chk(v, i == 2 ? 8'h01 : 8'h00);
    end
    $display("reset values done");
    for (int i = 0; i < 16; i++) begin
      v = i == 0 ? 8'h44 : i == 1 ? 8'hbb : 8'($random(seed));
      tx_serial_in <= 1'($random(seed));
      ufc_host_model_i.write(ADDR_LINE, v);
      ufc_host_model_i.read(ADDR_LINE, d);
      chk(d, v);
      chk({fmt.data_bits, fmt.par_en, fmt.brk, fmt.stop_two, fmt.stop_half}, exp_fmt(v));
      chk({6'h0, sel_divisor, tx_serial_out}, {6'h0, v[7], tx_serial_in & ~v[6]});
      if (v[3] && v[5]) chk({7'h0, fmt.par_value}, {7'h0, ~v[4]});
      if (v[3] && !v[5]) chk({7'h0, fmt.par_even}, {7'h0, v[4]});
    end
    ufc_host_model_i.write(ADDR_LINE, 8'h03);
    $display("line format done");
    for (int i = 0; i < 12; i++) begin
      v = 8'($random(seed));
      strobe_mode <= 1'($random(seed));
      irq_raw <= 1'($random(seed));
      ufc_host_model_i.write(ADDR_MODEM, v);
      #1 chk({terminal_ready_n, request_to_send_n, user_output_one_n, user_output_two_n,
        loop_enable, int_oe_n, int_out, 1'b0}, {~v[0] | v[4], ~v[1] | v[4], ~v[2], ~v[3],
        v[4], strobe_mode & ~v[3], irq_raw, 1'b0});
    end
    $display("modem control done");
    ufc_host_model_i.write(ADDR_FIFO_ISR, 8'h0f);
    #1 chk({5'h0, rx_flush, tx_flush, wake_irq_en}, 8'h06);
    @(posedge mclk);
    #1 chk({6'h0, rx_flush, tx_flush}, 8'h00);
    ufc_host_model_i.read(ADDR_FIFO_ISR, d);
    chk(d, 8'hc1);
    ufc_host_model_i.write(ADDR_FIFO_ISR, 8'h06);
    #1 chk({5'h0, rx_flush, tx_flush, fifo_enabled}, 8'h00);
    step(5'h01, 5'h00);
    chk({6'h0, rx_irq, tx_irq}, 8'h03);
    enhanced_en <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      ufc_host_model_i.write(ADDR_FIFO_ISR, {2'(c), 2'(3 - c), 4'h9});
      #1 chk({7'h0, wake_irq_en}, 8'h01);
      step(trig(2'(c)) - 5'h01, 5'h10);
      chk({6'h0, rx_irq, tx_irq}, 8'h00);
      step(trig(2'(c)), trig(2'(3 - c)) - 5'h01);
      chk({6'h0, rx_irq, tx_irq}, 8'h03);
    end
    $display("fifo control done");
    complete_run;
  end
endmodule // test_ufc_line_control
